// ===== common/tpwm_pkg.sv
package tpwm_pkg;

    // ****************************************************************
    // Register port geometry and offsets
    // ****************************************************************
    localparam int ADDR_WIDTH = 3;
    localparam int DATA_WIDTH = 16;

    localparam logic [2:0] REG_CONTROL = 3'h0;
    localparam logic [2:0] REG_COMPARE_A = 3'h1;
    localparam logic [2:0] REG_COMPARE_B = 3'h2;
    localparam logic [2:0] REG_CAPTURE = 3'h3;
    localparam logic [2:0] REG_COUNTER = 3'h4;
    localparam logic [2:0] REG_FLAGS = 3'h5;
    localparam logic [2:0] REG_PIN_DIR = 3'h6;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_CLK_LSB = 4;
    localparam int CTRL_ACT_A_LSB = 8;
    localparam int CTRL_ACT_B_LSB = 10;

    localparam int FLAG_OVERFLOW = 0;
    localparam int FLAG_COMPARE_A = 1;
    localparam int FLAG_COMPARE_B = 2;
    localparam int FLAG_CAPTURE = 3;

    localparam int DIR_A = 0;
    localparam int DIR_B = 1;

    // ****************************************************************
    // Waveform modes, output actions, prescaler codes
    // ****************************************************************
    localparam logic [3:0] MODE_PHASE_8 = 4'h1;
    localparam logic [3:0] MODE_PHASE_9 = 4'h2;
    localparam logic [3:0] MODE_PHASE_10 = 4'h3;
    localparam logic [3:0] MODE_FAST_8 = 4'h5;
    localparam logic [3:0] MODE_FAST_9 = 4'h6;
    localparam logic [3:0] MODE_FAST_10 = 4'h7;
    localparam logic [3:0] MODE_PHASE_CAPTURE = 4'ha;
    localparam logic [3:0] MODE_PHASE_COMPARE_A = 4'hb;
    localparam logic [3:0] MODE_FAST_CAPTURE = 4'he;
    localparam logic [3:0] MODE_FAST_COMPARE_A = 4'hf;

    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_NONINV = 2'h2;
    localparam logic [1:0] ACT_INV = 2'h3;

    localparam logic [2:0] CLK_STOP = 3'h0;
    localparam logic [2:0] CLK_DIV1 = 3'h1;
    localparam logic [2:0] CLK_DIV8 = 3'h2;
    localparam logic [2:0] CLK_DIV64 = 3'h3;
    localparam logic [2:0] CLK_DIV256 = 3'h4;
    localparam logic [2:0] CLK_DIV1024 = 3'h5;

    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03f;
    localparam logic [9:0] DIV256_MASK = 10'h0ff;
    localparam logic [9:0] DIV1024_MASK = 10'h3ff;

    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    localparam logic [15:0] RESET_VALUE = 16'h0000;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wrData;
        logic wrStrobe;
        logic rdStrobe;
    } tpwm_bus_req_type;

    typedef struct packed {
        logic level;
        logic enable;
    } tpwm_pin_type;

    typedef struct packed {
        logic [15:0] counter;
        logic countDown;
        logic [15:0] compAAct;
        logic [15:0] compABuf;
        logic [15:0] compBAct;
        logic [15:0] compBBuf;
        logic [15:0] capture;
        logic [3:0] mode;
        logic [2:0] clkSel;
        logic [1:0] actA;
        logic [1:0] actB;
        logic [1:0] pinDir;
        logic [3:0] flags;
        logic ocA;
        logic ocB;
        logic [9:0] prescale;
        logic [DATA_WIDTH-1:0] rdData;
        tpwm_pin_type pinA;
        tpwm_pin_type pinB;
    } tpwm_state_type;

endpackage

// ===== dv/tpwm_load.sv
`timescale 1ns/100ps
// ****
// Pin load with pull-down, counts high cycles
// ****
module tpwm_load
    import tpwm_pkg::*;
(
    // Clock
    input wire logic clock,
    // Pin and window restart
    input wire tpwm_pin_type pin,
    input wire logic clear,
    // High cycles seen
    output logic [15:0] highCnt
);
    // A released pin falls to the pull-down rather than keeping its last level
    wire logic padLevel = pin.enable ? pin.level : 1'b0;
    // Four-state count, so an unknown pin level cannot pass as low
    always @(posedge clock) highCnt <= clear ? 16'h0000 : highCnt + {15'h0000, padLevel};
endmodule

// ===== dv/tpwm_monitor.sv
`timescale 1ns/100ps
// ****
// Port checks
// ****
module tpwm_monitor
    import tpwm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Register port
    input wire tpwm_bus_req_type busReq,
    input wire logic [DATA_WIDTH-1:0] rdData,
    // Pins
    input wire tpwm_pin_type pinA,
    input wire tpwm_pin_type pinB
);
    logic [3:0] mode_q;
    logic [2:0] clk_q;
    wire logic rdCnt = busReq.rdStrobe && busReq.addr == REG_COUNTER;
    wire logic wrA = busReq.wrStrobe && busReq.addr == REG_COMPARE_A;
    wire logic wrCap = busReq.wrStrobe && busReq.addr == REG_CAPTURE;
    // Shadow of the control word, so checks know mode and tick rate
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= 4'h0;
            clk_q <= 3'h0;
        end else if (busReq.wrStrobe && busReq.addr == REG_CONTROL) begin
            mode_q <= busReq.wrData[CTRL_MODE_LSB +: 4];
            clk_q <= busReq.wrData[CTRL_CLK_LSB +: 3];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_PINA_GATED: assert property (!pinA.enable |-> !pinA.level)
        else $error("pin A level while disabled");
    AST_PINB_GATED: assert property (!pinB.enable |-> !pinB.level)
        else $error("pin B level while disabled");
    AST_DIR_OFF: assert property (
        busReq.wrStrobe && busReq.addr == REG_PIN_DIR && !busReq.wrData[DIR_A]
        |-> ##[1:3] !pinA.enable) else $error("pin A still enabled");
    AST_MASK_FAST8: assert property (
        wrA && mode_q == MODE_FAST_8 ##2 busReq.rdStrobe && busReq.addr == REG_COMPARE_A
        |=> rdData == ($past(busReq.wrData, 3) & TOP_8BIT)) else $error("compare not masked");
    AST_CAPTURE_FULL: assert property (
        wrCap ##2 busReq.rdStrobe && busReq.addr == REG_CAPTURE
        |=> rdData == $past(busReq.wrData, 3)) else $error("capture value altered");
    AST_FAST_STEP: assert property (
        clk_q == CLK_DIV1 && mode_q == MODE_FAST_10 && rdCnt ##2 rdCnt
        |=> rdData == (($past(rdData, 2) + 16'h2) & TOP_10BIT)) else $error("fast count step");
    AST_PHASE_STEP: assert property (
        clk_q == CLK_DIV1 && mode_q == MODE_PHASE_10 && rdCnt ##2 rdCnt |=> rdData inside
        {$past(rdData, 2), $past(rdData, 2) + 16'h2, $past(rdData, 2) - 16'h2})
        else $error("phase count step");
    AST_STOP_HOLD: assert property (
        clk_q == CLK_STOP && rdCnt ##2 rdCnt |=> rdData == $past(rdData, 2))
        else $error("counter moved while stopped");
endmodule
bind tpwm_timer tpwm_monitor mon (.clock(clock), .reset_n(reset_n), .busReq(busReq),
    .rdData(rdData), .pinA(pinA), .pinB(pinB));

// ===== dv/tpwm_timer_bench.sv
`timescale 1ns/100ps
module tpwm_timer_bench
    import tpwm_pkg::*;
();
    // ****
    // Harness
    // ****
    localparam logic [3:0] MM [7] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'he};
    localparam logic [15:0] MK [7] = '{16'hff, 16'h1ff, 16'h3ff, 16'hff, 16'h1ff, 16'h3ff, 16'hffff};
    localparam int DIV [5] = '{1, 8, 64, 256, 1024};
    localparam logic [3:0] DM [3] = '{MODE_FAST_8, MODE_PHASE_8, MODE_FAST_CAPTURE};
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clrA = 1'b1;
    tpwm_bus_req_type busReq = '0;
    logic [DATA_WIDTH-1:0] rdData;
    tpwm_pin_type pinA, pinB;
    logic [15:0] highA, highB;
    int hi, per, k;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] seed = 32'hf8be1edb;
    logic [15:0] v, a, top, cmp;
    logic [3:0] md;
    tpwm_timer uut (.clock(clock), .reset_n(reset_n), .busReq(busReq), .rdData(rdData),
        .pinA(pinA), .pinB(pinB));
    tpwm_load load (.clock(clock), .pin(pinA), .clear(clrA), .highCnt(highA));
    tpwm_load loadB (.clock(clock), .pin(pinB), .clear(clrA), .highCnt(highB));
    initial forever #2.5 clock = ~clock;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] cw(input logic [3:0] m, input logic [2:0] c, input logic [1:0] x);
        return {4'h0, x, x, 1'b0, c, m};
    endfunction
    task automatic summarize();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Hang guard sized well above the longest expected run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            errors++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One access every two cycles; entered and left at a rising edge
    task automatic acc(input logic w, input logic [2:0] ad, input logic [15:0] d);
        busReq <= '{addr: ad, wrData: d, wrStrobe: w, rdStrobe: !w};
        @(posedge clock);
        busReq.wrStrobe <= 1'b0;
        busReq.rdStrobe <= 1'b0;
        #1 v = rdData;
        @(posedge clock);
    endtask
    task automatic rst();
        reset_n <= 1'b0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
    endtask
    task automatic measure(input int w, input int e, input int eB);
        clrA <= 1'b1;
        @(posedge clock);
        clrA <= 1'b0;
        repeat (w) @(posedge clock);
        #1 chk("pin A high cycles", 16'(e), highA);
        chk("pin B high cycles", 16'(eB), highB);
        @(posedge clock);
    endtask
    // ****
    // Scenarios
    // ****
    initial begin
        rst();
        for (k = 0; k < 8; k++) begin
            acc(0, 3'(k), 16'h0);
            chk("reset read", 16'h0, v);
        end
        acc(0, REG_COUNTER, 16'h0);
        acc(0, REG_COUNTER, 16'h0);
        chk("stopped counter", 16'h0, v);
        foreach (MM[i]) begin
            seed = lfsr(seed);
            acc(1, REG_CONTROL, 16'(MM[i]));
            acc(1, REG_COMPARE_A, seed[15:0]);
            acc(0, REG_COMPARE_A, 16'h0);
            chk("compare mask", seed[15:0] & MK[i], v);
        end
        acc(1, REG_CAPTURE, seed[31:16]);
        acc(0, REG_CAPTURE, 16'h0);
        chk("capture", seed[31:16], v);
        foreach (DIV[i]) begin
            acc(1, REG_CONTROL, cw(MODE_FAST_10, 3'(i + 1), ACT_NONE));
            acc(0, REG_COUNTER, 16'h0);
            a = v;
            repeat (2 * DIV[i] - 2) @(posedge clock);
            acc(0, REG_COUNTER, 16'h0);
            chk("prescaled count", (a + 16'h2) & TOP_10BIT, v);
        end
        acc(1, REG_CONTROL, cw(MODE_PHASE_10, CLK_DIV1, ACT_NONE));
        acc(0, REG_COUNTER, 16'h0);
        acc(0, REG_COUNTER, 16'h0);
        for (k = 0; k < 2; k++) begin
            rst();
            seed = lfsr(seed);
            top = 16'h10 + 16'(seed[3:0]); // kept above the minimum TOP
            md = k != 0 ? MODE_PHASE_COMPARE_A : MODE_FAST_COMPARE_A;
            acc(1, REG_PIN_DIR, 16'h1);
            acc(1, REG_COMPARE_A, top); // TOP fixed before counting starts
            acc(1, REG_CONTROL, cw(md, CLK_DIV1, ACT_TOGGLE));
            acc(0, REG_COUNTER, 16'h0);
            a = v;
            repeat (top - 2) @(posedge clock);
            acc(0, REG_COUNTER, 16'h0);
            chk("count", k != 0 ? top - a : (a + top) % (top + 16'h1), v);
            hi = k != 0 ? 4 * top : 2 * top + 2;
            measure(2 * hi, hi, 0);
            acc(1, REG_CONTROL, cw(md, CLK_STOP, ACT_TOGGLE));
            acc(0, REG_FLAGS, 16'h0);
            chk("flags", 16'h7, v);
            acc(1, REG_FLAGS, 16'hf);
            acc(0, REG_FLAGS, 16'h0);
            chk("flags cleared", 16'h0, v);
        end
        foreach (DM[i]) begin
            rst();
            acc(1, REG_CAPTURE, TOP_8BIT);
            acc(1, REG_PIN_DIR, 16'h3);
            for (k = 0; k < 6; k++) begin
                seed = lfsr(seed);
                cmp = k < 2 ? 16'h0 : (k < 4 ? TOP_8BIT : 16'(seed[7:0]));
                acc(1, REG_COMPARE_A, cmp);
                acc(1, REG_COMPARE_B, cmp);
                acc(1, REG_CONTROL, cw(DM[i], CLK_DIV1, k[0] ? ACT_INV : ACT_NONINV));
                repeat (1100) @(posedge clock);
                hi = i == 1 ? 4 * cmp : 2 * cmp + 2;
                per = i == 1 ? 1020 : 512;
                hi = k[0] ? per - hi : hi;
                measure(per, hi, hi);
            end
            acc(0, REG_FLAGS, 16'h0);
            chk("pwm flags", i == 2 ? 16'hf : 16'h7, v);
        end
        acc(1, REG_PIN_DIR, 16'h0);
        measure(256, 0, 0);
        summarize();
    end
endmodule

// ===== rtl/tpwm_timer.sv
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module tpwm_timer
    import tpwm_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Register port
    input wire tpwm_bus_req_type busReq,
    output logic [DATA_WIDTH-1:0] rdData,
    // Compare output pins
    output tpwm_pin_type pinA,
    output tpwm_pin_type pinB
);

    // ****************************************************************
    // Mode decoding
    // ****************************************************************
    function automatic logic isFast(input logic [3:0] mode);
        return (mode == MODE_FAST_8) || (mode == MODE_FAST_9) || (mode == MODE_FAST_10) ||
               (mode == MODE_FAST_CAPTURE) || (mode == MODE_FAST_COMPARE_A);
    endfunction

    function automatic logic isPhase(input logic [3:0] mode);
        return (mode == MODE_PHASE_8) || (mode == MODE_PHASE_9) ||
               (mode == MODE_PHASE_10) || (mode == MODE_PHASE_CAPTURE) ||
               (mode == MODE_PHASE_COMPARE_A);
    endfunction

    // Outside the PWM modes compare writes bypass the buffer
    function automatic logic isPwm(input logic [3:0] mode);
        return isFast(mode) || isPhase(mode);
    endfunction

    // One prescaler tap: every low bit of the free counter is set
    function automatic logic prescaleDone(input logic [9:0] count, input logic [9:0] mask);
        return (count & mask) == mask;
    endfunction

    // Bits kept by a compare write; all ones outside the fixed-TOP modes
    function automatic logic [15:0] resolutionMask(input logic [3:0] mode);
        logic [15:0] mask;
        case (mode)
            MODE_PHASE_8, MODE_FAST_8: begin
                mask = TOP_8BIT;
            end
            MODE_PHASE_9, MODE_FAST_9: begin
                mask = TOP_9BIT;
            end
            MODE_PHASE_10, MODE_FAST_10: begin
                mask = TOP_10BIT;
            end
            default: begin
                mask = COUNT_MAX;
            end
        endcase
        return mask;
    endfunction

    function automatic logic [15:0] topOf(input logic [3:0] mode, input logic [15:0] compA,
                                          input logic [15:0] capture);
        logic [15:0] top;
        case (mode)
            MODE_PHASE_CAPTURE, MODE_FAST_CAPTURE: begin
                top = capture;
            end
            MODE_PHASE_COMPARE_A, MODE_FAST_COMPARE_A: begin
                top = compA;
            end
            default: begin
                top = resolutionMask(mode);
            end
        endcase
        return top;
    endfunction

    // New output level. Levels are given for non-inverted output; the
    // forced event (wrap in fast PWM) outranks a match in the same cycle.
    function automatic logic waveLevel(input logic oc, input logic [1:0] act,
                                       input logic toggleOk, input logic match,
                                       input logic matchLvl, input logic wrapEvt,
                                       input logic wrapLvl);
        logic lvl;
        lvl = oc;
        case (act)
            ACT_TOGGLE: begin
                if (toggleOk && match) begin
                    lvl = ~oc;
                end
            end
            ACT_NONINV, ACT_INV: begin
                if (wrapEvt) begin
                    lvl = wrapLvl ^ (act == ACT_INV);
                end else if (match) begin
                    lvl = matchLvl ^ (act == ACT_INV);
                end
            end
            default: begin
                lvl = oc;
            end
        endcase
        return lvl;
    endfunction

    // A disconnected pin is held low as well as released, so no stale
    // level shows the moment its direction bit comes back on
    function automatic tpwm_pin_type pinDrive(input logic dir, input logic connected,
                                              input logic lvl);
        tpwm_pin_type pin;
        pin.enable = dir && connected;
        pin.level = pin.enable && lvl;
        return pin;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    tpwm_state_type state_q;
    tpwm_state_type state_d;

    // Decoded each cycle from state_q and busReq; none of these is a flop
    logic tick;
    logic [15:0] top;
    logic atTop;
    logic atBottom;
    logic matchA;
    logic matchB;
    logic effDown;
    logic toggleOk;
    logic [3:0] flagSet;
    logic [3:0] flagClr;
    logic [15:0] maskedWrite;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        flagSet = 4'h0;
        flagClr = 4'h0;
        effDown = 1'b0;

        // Prescaler runs free so a change of division takes effect at once
        state_d.prescale = state_q.prescale + 10'h001;
        case (state_q.clkSel)
            CLK_DIV1: begin
                tick = 1'b1;
            end
            CLK_DIV8: begin
                tick = prescaleDone(state_q.prescale, DIV8_MASK);
            end
            CLK_DIV64: begin
                tick = prescaleDone(state_q.prescale, DIV64_MASK);
            end
            CLK_DIV256: begin
                tick = prescaleDone(state_q.prescale, DIV256_MASK);
            end
            CLK_DIV1024: begin
                tick = prescaleDone(state_q.prescale, DIV1024_MASK);
            end
            default: begin
                tick = 1'b0;
            end
        endcase

        top = topOf(state_q.mode, state_q.compAAct, state_q.capture);
        atTop = state_q.counter == top;
        atBottom = state_q.counter == COUNT_BOTTOM;
        // Compare A stays an ordinary channel when capture defines TOP
        matchA = state_q.counter == state_q.compAAct;
        matchB = state_q.counter == state_q.compBAct;
        // Half duty needs compare A as TOP, so toggling is limited to those modes
        toggleOk = (state_q.mode == MODE_FAST_COMPARE_A) ||
                   (state_q.mode == MODE_PHASE_COMPARE_A);

        // ************************************************************
        // Counting, flags and waveform on timer clock enables
        // ************************************************************
        if (tick && isFast(state_q.mode)) begin
            state_d.countDown = 1'b0;
            if (atTop) begin
                state_d.counter = COUNT_BOTTOM;
                flagSet[FLAG_OVERFLOW] = 1'b1;
                state_d.compAAct = state_q.compABuf;
                state_d.compBAct = state_q.compBBuf;
                if (state_q.mode == MODE_FAST_CAPTURE) begin
                    flagSet[FLAG_CAPTURE] = 1'b1;
                end
                if (state_q.mode == MODE_FAST_COMPARE_A) begin
                    flagSet[FLAG_COMPARE_A] = 1'b1;
                end
            end else begin
                // Past a lowered capture TOP this runs on through the wrap
                state_d.counter = state_q.counter + COUNT_ONE;
            end
            // Wrap sets, match clears: zero gives a spike, TOP a constant
            state_d.ocA = waveLevel(state_q.ocA, state_q.actA, toggleOk, matchA,
                                    1'b0, atTop, 1'b1);
            state_d.ocB = waveLevel(state_q.ocB, state_q.actB, 1'b0, matchB,
                                    1'b0, atTop, 1'b1);
            flagSet[FLAG_COMPARE_A] = flagSet[FLAG_COMPARE_A] | matchA;
            flagSet[FLAG_COMPARE_B] = matchB;
        end else if (tick && isPhase(state_q.mode)) begin
            if (!state_q.countDown) begin
                if (atTop) begin
                    // TOP is seen for one enable only, then the slope turns
                    state_d.countDown = 1'b1;
                    state_d.counter = top - COUNT_ONE;
                    state_d.compAAct = state_q.compABuf;
                    state_d.compBAct = state_q.compBBuf;
                    if (state_q.mode == MODE_PHASE_CAPTURE) begin
                        flagSet[FLAG_CAPTURE] = 1'b1;
                    end
                    if (state_q.mode == MODE_PHASE_COMPARE_A) begin
                        flagSet[FLAG_COMPARE_A] = 1'b1;
                    end
                end else begin
                    // A TOP lowered below the count runs on through the 16-bit wrap
                    state_d.counter = state_q.counter + COUNT_ONE;
                end
            end else begin
                if (atBottom) begin
                    state_d.countDown = 1'b0;
                    state_d.counter = COUNT_ONE;
                    flagSet[FLAG_OVERFLOW] = 1'b1;
                end else begin
                    state_d.counter = state_q.counter - COUNT_ONE;
                end
            end
            // A match at TOP counts as falling slope, at bottom as rising:
            // bottom then holds low and TOP holds high
            if (atTop) begin
                effDown = 1'b1;
            end else if (atBottom) begin
                effDown = 1'b0;
            end else begin
                effDown = state_q.countDown;
            end
            state_d.ocA = waveLevel(state_q.ocA, state_q.actA, toggleOk, matchA,
                                    effDown, 1'b0, 1'b0);
            state_d.ocB = waveLevel(state_q.ocB, state_q.actB, 1'b0, matchB,
                                    effDown, 1'b0, 1'b0);
            flagSet[FLAG_COMPARE_A] = flagSet[FLAG_COMPARE_A] | matchA;
            flagSet[FLAG_COMPARE_B] = matchB;
        end

        // ************************************************************
        // Register writes
        // ************************************************************
        maskedWrite = busReq.wrData & resolutionMask(state_q.mode);
        if (busReq.wrStrobe) begin
            case (busReq.addr)
                REG_CONTROL: begin
                    state_d.mode = busReq.wrData[CTRL_MODE_LSB +: 4];
                    state_d.clkSel = busReq.wrData[CTRL_CLK_LSB +: 3];
                    state_d.actA = busReq.wrData[CTRL_ACT_A_LSB +: 2];
                    state_d.actB = busReq.wrData[CTRL_ACT_B_LSB +: 2];
                end
                REG_COMPARE_A: begin
                    state_d.compABuf = maskedWrite;
                    // Outside the PWM modes there is no double buffering
                    if (!isPwm(state_q.mode)) begin
                        state_d.compAAct = maskedWrite;
                    end
                end
                REG_COMPARE_B: begin
                    state_d.compBBuf = maskedWrite;
                    if (!isPwm(state_q.mode)) begin
                        state_d.compBAct = maskedWrite;
                    end
                end
                REG_CAPTURE: begin
                    // Unbuffered: a new TOP is compared from the very next tick
                    state_d.capture = busReq.wrData;
                end
                REG_FLAGS: begin
                    flagClr = busReq.wrData[3:0];
                end
                REG_PIN_DIR: begin
                    state_d.pinDir = busReq.wrData[1:0];
                end
                default: begin
                    flagClr = 4'h0;
                end
            endcase
        end
        // A flag raised in the cycle software clears it survives
        state_d.flags = (state_q.flags & ~flagClr) | flagSet;

        // ************************************************************
        // Read data, valid only in the cycle after the strobe
        // ************************************************************
        state_d.rdData = '0;
        if (busReq.rdStrobe) begin
            case (busReq.addr)
                REG_CONTROL: begin
                    state_d.rdData = {4'h0, state_q.actB, state_q.actA, 1'b0,
                                      state_q.clkSel, state_q.mode};
                end
                REG_COMPARE_A: begin
                    state_d.rdData = state_q.compABuf;
                end
                REG_COMPARE_B: begin
                    state_d.rdData = state_q.compBBuf;
                end
                REG_CAPTURE: begin
                    state_d.rdData = state_q.capture;
                end
                REG_COUNTER: begin
                    state_d.rdData = state_q.counter;
                end
                REG_FLAGS: begin
                    state_d.rdData = {12'h000, state_q.flags};
                end
                REG_PIN_DIR: begin
                    state_d.rdData = {14'h0000, state_q.pinDir};
                end
                default: begin
                    state_d.rdData = '0;
                end
            endcase
        end

        // ************************************************************
        // Pins: the level is only driven while direction is output
        // ************************************************************
        state_d.pinA = pinDrive(state_d.pinDir[DIR_A], state_d.actA != ACT_NONE,
                                state_d.ocA);
        // Channel B has no toggle action, so action one leaves it unconnected
        state_d.pinB = pinDrive(state_d.pinDir[DIR_B], state_d.actB[1], state_d.ocB);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            // Constants only: the struct holds every flop of the block
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdData = state_q.rdData;
    assign pinA = state_q.pinA;
    assign pinB = state_q.pinB;

endmodule
